// ---- rtl/esc_pkg.sv ----
// Package for the enhanced special-function control set.
// Assumes a CPU-side register port on sys_clk with one-cycle read latency.
package esc_pkg;
    localparam logic [7:0] ADDR_AUX_CONFIG   = 8'h8e;
    localparam logic [7:0] ADDR_PORT_FOUR    = 8'hc0;
    localparam logic [7:0] ADDR_WDT_CONTROL  = 8'hc1;
    localparam logic [7:0] ADDR_FP_DATA      = 8'hc2;
    localparam logic [7:0] ADDR_FP_ADDR_HIGH = 8'hc3;
    localparam logic [7:0] ADDR_FP_ADDR_LOW  = 8'hc4;
    localparam logic [7:0] ADDR_FP_COMMAND   = 8'hc5;
    localparam logic [7:0] ADDR_FP_TRIGGER   = 8'hc6;
    localparam logic [7:0] ADDR_FP_CONTROL   = 8'hc7;
    // Own registers for events and wake control
    localparam logic [7:0] ADDR_IRQ_STATUS   = 8'hd0;
    localparam logic [7:0] ADDR_IRQ_MASK     = 8'hd1;
    localparam logic [7:0] ADDR_WAKE_CONTROL = 8'hd2;

    localparam logic [7:0] AUX_RESET     = 8'h00;
    localparam logic [7:0] WDT_RESET     = 8'h00;
    localparam logic [7:0] PORT_RESET    = 8'hff;
    localparam logic [7:0] UNLOCK_FIRST  = 8'h5a;
    localparam logic [7:0] UNLOCK_SECOND = 8'ha5;
    localparam logic [15:0] FLASH_BASE   = 16'h0000;
    // Wake delay end counts, one less than the clocks waited
    localparam logic [15:0] WAKE_LAST_0  = 16'h7fff;
    localparam logic [15:0] WAKE_LAST_1  = 16'h3fff;
    localparam logic [15:0] WAKE_LAST_2  = 16'h1fff;
    localparam logic [15:0] WAKE_LAST_3  = 16'h0fff;

    localparam int LEGACY_DIV     = 12;
    localparam int PORT_ACCESS_CLKS = 4;
    localparam int WATCHDOG_RESET_FLAG_BIT   = 7;
    localparam int WDT_EN_BIT     = 5;
    localparam int WDT_CLR_BIT    = 4;

    // Status bit positions
    localparam int EV_FLASH_DONE = 0;
    localparam int EV_WAKE       = 1;
    localparam int EV_BAD_UNLOCK = 2;

    typedef struct packed {
        logic timer0_undivided_clock;
        logic timer1_undivided_clock;
        logic serial_mode0_speedup;
        logic baud_gen_run;
        logic second_port_baud_double;
        logic baud_gen_undivided_clock;
        logic external_ram_select;
        logic first_port_baud_source;
    } esc_aux_t;

    typedef struct packed {
        logic       watchdog_reset_flag;
        logic       unused6;
        logic       watchdog_enable_bit;
        logic       watchdog_clear_bit;
        logic       watchdog_count_in_idle;
        logic [2:0] prescale;
    } esc_wdt_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } esc_bus_t;

    typedef enum logic [1:0] {
        UNL_IDLE  = 2'b00,
        UNL_ARMED = 2'b01
    } esc_unlock_t;
endpackage

// ---- rtl/esc_sfr_set.sv ----
// Special-function control registers of the enhanced microcontroller.
// Assumes the CPU core drives esc_bus_t on sys_clk; pins arrive unsynchronised.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module esc_sfr_set #(
    parameter int WDT_PRESCALE_W = 3
) (
    input  wire logic              sys_clk,         // 200 MHz clock
    input  wire logic              rst_n,           // Synchronous reset, low
    input  wire esc_pkg::esc_bus_t bus,             // Register port
    output logic [7:0]             rdata,           // Read data, next cycle
    input  wire logic [7:0]        port_four_in,    // Port four pin levels
    output logic [7:0]             port_four_out,   // Port four drive latch
    input  wire logic              fetch_pin_in,    // Former strobe pin level
    output logic                   fetch_pin_out,   // Former strobe pin drive
    output logic                   latch_pin_out,   // Address-latch pin
    input  wire logic              ext_irq_n,       // External interrupt pin
    input  wire logic              ext_irq_edge,    // Trigger mode: 1 falling
    input  wire logic              power_down,      // Core in power-down
    input  wire logic              update_done,     // In-system update ended
    input  wire logic              flash_ready,     // Flash macro finished
    output logic                   flash_start,     // Flash command pulse
    output logic [15:0]            flash_addr,      // Flash address
    output logic [7:0]             flash_cmd,       // Flash command
    output logic                   timer_tick0,     // Timer0 count enable
    output logic                   timer_tick1,     // Timer1 count enable
    output logic                   baud_from_gen,   // First port uses generator
    output logic                   baud_gen_tick,   // Baud generator enable
    output logic                   port_strobe,     // Port access complete
    output logic                   wake_resume,     // Resume after wake delay
    output logic                   wdt_enabled,     // Watchdog running
    output logic                   irq              // Level interrupt
);
    import esc_pkg::*;

    // Refuse a prescale width the register layout cannot hold
    if (WDT_PRESCALE_W != 3) begin : g_bad_width
        $error("prescale width must be 3");
    end

    esc_aux_t    aux_config;
    esc_wdt_t    watchdog_control;
    logic [7:0]  port_four_latch;
    logic [7:0]  flash_prog_data;
    logic [7:0]  flash_prog_addr_high;
    logic [7:0]  flash_prog_addr_low;
    logic [7:0]  flash_prog_command;
    logic [7:0]  flash_prog_control;
    logic [7:0]  irq_status;
    logic [7:0]  irq_mask;
    logic [1:0]  wake_sel;
    esc_unlock_t unlock_state;
    logic [7:0]  p4_meta;
    logic [7:0]  p4_sync;
    logic        fetch_meta;
    logic        fetch_sync;
    logic        irq_meta;
    logic        irq_sync;
    logic        irq_prev;
    logic [3:0]  div12;
    logic [1:0]  port_div;
    logic [15:0] wake_count;
    logic        waking;
    logic        ev_done;
    logic        ev_wake;
    logic        ev_bad;
    logic        wake_req;
    logic [15:0] wake_limit;
    logic        wr_trig;

    localparam logic [3:0] DIV12_LAST = 4'(LEGACY_DIV - 1);
    localparam logic [1:0] PORT_LAST  = 2'(PORT_ACCESS_CLKS - 1);

    assign wr_trig = bus.wr && bus.addr == ADDR_FP_TRIGGER;

    // Pin synchronisers
    always_ff @(posedge sys_clk) begin
        p4_meta    <= port_four_in;
        p4_sync    <= p4_meta;
        fetch_meta <= fetch_pin_in;
        fetch_sync <= fetch_meta;
        irq_meta   <= ext_irq_n;
        irq_sync   <= irq_meta;
        irq_prev   <= irq_sync;
    end

    // Auxiliary configuration register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            aux_config <= esc_aux_t'(AUX_RESET);
        end else if (bus.wr && bus.addr == ADDR_AUX_CONFIG) begin
            aux_config <= esc_aux_t'(bus.wdata);
        end
    end

    // Port four latch and plain I/O pin
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            port_four_latch <= PORT_RESET;
            fetch_pin_out   <= 1'b1;
        end else if (bus.wr && bus.addr == ADDR_PORT_FOUR) begin
            port_four_latch <= bus.wdata;
        end
    end

    // Flash self-programming registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            flash_prog_data      <= 8'h00;
            flash_prog_addr_high <= FLASH_BASE[15:8];
            flash_prog_addr_low  <= FLASH_BASE[7:0];
            flash_prog_command   <= 8'h00;
            flash_prog_control   <= 8'h00;
        end else if (bus.wr) begin
            unique case (bus.addr)
                ADDR_FP_DATA:      flash_prog_data      <= bus.wdata;
                ADDR_FP_ADDR_HIGH: flash_prog_addr_high <= bus.wdata;
                ADDR_FP_ADDR_LOW:  flash_prog_addr_low  <= bus.wdata;
                ADDR_FP_COMMAND:   flash_prog_command   <= bus.wdata;
                ADDR_FP_CONTROL:   flash_prog_control   <= bus.wdata;
                default: ;
            endcase
        end
    end

    // Two-write unlock sequence for flash commands
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            unlock_state <= UNL_IDLE;
            flash_start  <= 1'b0;
            ev_bad       <= 1'b0;
        end else begin
            flash_start <= 1'b0;
            ev_bad      <= 1'b0;
            if (wr_trig) begin
                unique case (unlock_state)
                    UNL_IDLE: begin
                        if (bus.wdata == UNLOCK_FIRST) begin
                            unlock_state <= UNL_ARMED;
                        end else begin
                            ev_bad <= 1'b1;
                        end
                    end
                    UNL_ARMED: begin
                        unlock_state <= UNL_IDLE;
                        if (bus.wdata == UNLOCK_SECOND) begin
                            flash_start <= 1'b1;
                        end else begin
                            ev_bad <= 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    // Flash request outputs
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            flash_addr <= FLASH_BASE;
            flash_cmd  <= 8'h00;
            ev_done    <= 1'b0;
        end else begin
            flash_addr <= {flash_prog_addr_high, flash_prog_addr_low};
            flash_cmd  <= flash_prog_command;
            ev_done    <= flash_ready;
        end
    end

    // Watchdog control register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            watchdog_control <= esc_wdt_t'(WDT_RESET);
        end else if (update_done) begin
            watchdog_control.watchdog_enable_bit <= 1'b1;
        end else if (bus.wr && bus.addr == ADDR_WDT_CONTROL) begin
            watchdog_control.watchdog_reset_flag <=
                watchdog_control.watchdog_reset_flag & ~bus.wdata[WATCHDOG_RESET_FLAG_BIT];
            watchdog_control.watchdog_enable_bit <=
                watchdog_control.watchdog_enable_bit | bus.wdata[WDT_EN_BIT];
            watchdog_control.watchdog_clear_bit <= bus.wdata[WDT_CLR_BIT];
            watchdog_control.watchdog_count_in_idle <= bus.wdata[3];
            watchdog_control.prescale <= bus.wdata[2:0];
        end else begin
            watchdog_control.watchdog_clear_bit <= 1'b0;
        end
    end

    // Clock/12 and four-clock port access enables
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            div12    <= 4'h0;
            port_div <= 2'h0;
        end else begin
            div12    <= (div12 == DIV12_LAST) ? 4'h0 : div12 + 4'h1;
            port_div <= port_div + 2'h1;
        end
    end

    // Timer, baud and port timing enables
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            timer_tick0   <= 1'b0;
            timer_tick1   <= 1'b0;
            baud_from_gen <= 1'b0;
            baud_gen_tick <= 1'b0;
            port_strobe   <= 1'b0;
            latch_pin_out <= 1'b0;
        end else begin
            timer_tick0 <= aux_config.timer0_undivided_clock | (div12 == DIV12_LAST);
            timer_tick1 <= aux_config.timer1_undivided_clock | (div12 == DIV12_LAST);
            baud_from_gen <= aux_config.first_port_baud_source;
            baud_gen_tick <= aux_config.baud_gen_run &
                (aux_config.baud_gen_undivided_clock | (div12 == DIV12_LAST));
            port_strobe <= (port_div == PORT_LAST);
            latch_pin_out <= 1'b0;
        end
    end

    // Power-down wake from level or falling edge
    assign wake_req = power_down &&
        (ext_irq_edge ? (irq_prev && !irq_sync) : !irq_sync);
    always_comb begin
        unique case (wake_sel)
            2'd0: wake_limit = WAKE_LAST_0;
            2'd1: wake_limit = WAKE_LAST_1;
            2'd2: wake_limit = WAKE_LAST_2;
            2'd3: wake_limit = WAKE_LAST_3;
        endcase
    end

    // Wake delay counter
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            waking      <= 1'b0;
            wake_count  <= 16'h0000;
            wake_resume <= 1'b0;
            ev_wake     <= 1'b0;
        end else begin
            wake_resume <= 1'b0;
            ev_wake     <= 1'b0;
            if (!waking && !wake_resume && wake_req) begin // No restart on resume
                waking     <= 1'b1;
                wake_count <= 16'h0000;
            end else if (waking) begin
                wake_count <= wake_count + 16'h0001;
                if (wake_count == wake_limit) begin
                    waking      <= 1'b0;
                    wake_resume <= 1'b1;
                    ev_wake     <= 1'b1;
                end
            end
        end
    end

    // Interrupt status, mask and wake selection
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irq_status <= 8'h00;
            irq_mask   <= 8'h00;
            wake_sel   <= 2'd0;
        end else begin
            if (bus.wr && bus.addr == ADDR_IRQ_MASK) irq_mask <= bus.wdata;
            if (bus.wr && bus.addr == ADDR_WAKE_CONTROL) wake_sel <= bus.wdata[1:0];
            irq_status <= (irq_status &
                ~((bus.wr && bus.addr == ADDR_IRQ_STATUS) ? bus.wdata : 8'h00))
                | {5'b0, ev_bad, ev_wake, ev_done};
        end
    end

    // Registered outputs
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irq           <= 1'b0;
            port_four_out <= PORT_RESET;
            wdt_enabled   <= 1'b0;
        end else begin
            irq           <= |(irq_status & irq_mask);
            port_four_out <= port_four_latch;
            wdt_enabled   <= watchdog_control.watchdog_enable_bit;
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (bus.rd) begin
            unique case (bus.addr)
                ADDR_AUX_CONFIG:   rdata <= aux_config;
                ADDR_PORT_FOUR:    rdata <= p4_sync;
                ADDR_WDT_CONTROL:  rdata <= {watchdog_control[7], 1'b0, watchdog_control[5:0]};
                ADDR_FP_DATA:      rdata <= flash_prog_data;
                ADDR_FP_ADDR_HIGH: rdata <= flash_prog_addr_high;
                ADDR_FP_ADDR_LOW:  rdata <= flash_prog_addr_low;
                ADDR_FP_COMMAND:   rdata <= flash_prog_command;
                ADDR_FP_TRIGGER:   rdata <= {7'b0, fetch_sync};
                ADDR_FP_CONTROL:   rdata <= flash_prog_control;
                ADDR_IRQ_STATUS:   rdata <= irq_status;
                ADDR_IRQ_MASK:     rdata <= irq_mask;
                ADDR_WAKE_CONTROL: rdata <= {6'b0, wake_sel};
                default:           rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end
endmodule // esc_sfr_set
`default_nettype wire

// ---- tb/esc_sfr_chk.sv ----
// Checker for the special-function control set.
// Assumes it is bound to esc_sfr_set and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module esc_sfr_chk (
    input wire logic              sys_clk,       // Clock
    input wire logic              rst_n,         // Sync reset, low
    input wire esc_pkg::esc_bus_t bus,           // Register port
    input wire logic [7:0]        rdata,         // Read data
    input wire logic              latch_pin_out, // Address-latch pin
    input wire logic              fetch_pin_out, // Former strobe pin
    input wire logic              timer_tick0,   // Timer0 enable
    input wire logic              timer_tick1,   // Timer1 enable
    input wire logic              baud_from_gen, // Baud source select
    input wire logic              port_strobe,   // Port access pulse
    input wire logic              flash_start,   // Flash launch
    input wire logic              update_done,   // Update ended
    input wire logic              wdt_enabled    // Watchdog running
);
    import esc_pkg::*;
    logic [7:0] aux_sh; // Copy of the aux register
    logic       armed;  // First unlock byte seen
    wire        trig_wr = bus.wr && bus.addr == ADDR_FP_TRIGGER;
    wire        key_ok  = trig_wr && armed && bus.wdata == UNLOCK_SECOND;

    // Track aux writes and the unlock state
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            aux_sh <= 8'h00;
            armed  <= 1'b0;
        end else begin
            if (bus.wr && bus.addr == ADDR_AUX_CONFIG)
                aux_sh <= bus.wdata;
            if (trig_wr)
                armed <= bus.wdata == UNLOCK_FIRST;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_key;
        trig_wr && bus.wdata == UNLOCK_FIRST ##1 trig_wr && bus.wdata == UNLOCK_SECOND;
    endsequence
    sequence s_gap12;
        !timer_tick0 [*8] ##1 !timer_tick0 [*3] ##1 timer_tick0;
    endsequence

    property p_div12;
        disable iff (!rst_n || aux_sh[7]) timer_tick0 |=> s_gap12;
    endproperty
    property p_undiv1;      aux_sh[6] [*3] |-> timer_tick1;                   endproperty
    property p_baud;        $stable(aux_sh[0]) |-> baud_from_gen == aux_sh[0]; endproperty
    property p_pins;        latch_pin_out == 1'b0 && fetch_pin_out == 1'b1;   endproperty
    property p_port4;       port_strobe |=> !port_strobe [*3] ##1 port_strobe; endproperty
    property p_launch;      s_key |-> ##[1:2] flash_start;                    endproperty
    property p_no_stray;    flash_start |-> $past(key_ok) || $past(key_ok, 2); endproperty
    property p_rd_idle;     !$past(bus.rd) |-> rdata == 8'h00;                endproperty
    property p_wdt;         update_done |-> ##[1:3] wdt_enabled;              endproperty
    property p_wdt_hold;    wdt_enabled |=> wdt_enabled;                      endproperty

    a_div12:    assert property (p_div12) else $error("timer0 not at clock/12");
    a_undiv1:   assert property (p_undiv1) else $error("timer1 not undivided");
    a_baud:     assert property (p_baud) else $error("baud source wrong");
    a_pins:     assert property (p_pins) else $error("latch or fetch pin wrong");
    a_port4:    assert property (p_port4) else $error("port access not 4 clocks");
    a_launch:   assert property (p_launch) else $error("unlock did not launch");
    a_no_stray: assert property (p_no_stray) else $error("launch without unlock");
    a_rd_idle:  assert property (p_rd_idle) else $error("read data outside slot");
    a_wdt:      assert property (p_wdt) else $error("watchdog not enabled");
    a_wdt_hold: assert property (p_wdt_hold) else $error("watchdog dropped");
endmodule // esc_sfr_chk

bind esc_sfr_set esc_sfr_chk i_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .latch_pin_out(latch_pin_out), .fetch_pin_out(fetch_pin_out),
    .timer_tick0(timer_tick0), .timer_tick1(timer_tick1), .baud_from_gen(baud_from_gen),
    .port_strobe(port_strobe), .flash_start(flash_start), .update_done(update_done),
    .wdt_enabled(wdt_enabled)
);
`default_nettype wire

// ---- tb/esc_sfr_set_bench.sv ----
// Self-checking bench for the special-function control set.
// Assumes the package, the design and its checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module esc_sfr_set_bench;
    import esc_pkg::*;
    logic        sys_clk, rst_n, fetch_pin_in, ext_irq_n, ext_irq_edge, power_down;
    logic        update_done, flash_ready, fetch_pin_out, latch_pin_out, flash_start;
    logic        timer_tick0, timer_tick1, baud_from_gen, baud_gen_tick, port_strobe;
    logic        wake_resume, wdt_enabled, irq, rd_q;
    logic [7:0]  port_four_in, rdata, port_four_out, flash_cmd;
    logic [15:0] flash_addr;
    logic [31:0] seed;
    logic [7:0]  expq[$];
    esc_bus_t    bus;
    int          mismatches, cmp_count, n, m, k;

    esc_sfr_set i_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
        .port_four_in(port_four_in), .port_four_out(port_four_out),
        .fetch_pin_in(fetch_pin_in), .fetch_pin_out(fetch_pin_out),
        .latch_pin_out(latch_pin_out), .ext_irq_n(ext_irq_n), .ext_irq_edge(ext_irq_edge),
        .power_down(power_down), .update_done(update_done), .flash_ready(flash_ready),
        .flash_start(flash_start), .flash_addr(flash_addr), .flash_cmd(flash_cmd),
        .timer_tick0(timer_tick0), .timer_tick1(timer_tick1), .baud_from_gen(baud_from_gen),
        .baud_gen_tick(baud_gen_tick), .port_strobe(port_strobe), .wake_resume(wake_resume),
        .wdt_enabled(wdt_enabled), .irq(irq)
    );

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic check(input string what, input logic [15:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done;
        if (mismatches == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // One bus cycle, driven just after the edge
    task automatic op(input logic w, r, input logic [7:0] a, d);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: d, wr: w, rd: r};
    endtask

    task automatic wr(input logic [7:0] a, d);
        op(1'b1, 1'b0, a, d);
    endtask

    task automatic rd(input logic [7:0] a, e);
        op(1'b0, 1'b1, a, 8'h00);
        expq.push_back(e);
    endtask

    task automatic idle(input int k);
        repeat (k) op(1'b0, 1'b0, 8'h00, 8'h00);
    endtask

    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
    endtask

    // Bounded wait for a high level, counted in cycles
    task automatic wait_hi(ref logic s, input int lim, output int c);
        c = 0;
        do begin
            @(negedge sys_clk);
            c++;
            if (c > lim) begin
                mismatches++;
                test_done();
            end
        end while (s !== 1'b1);
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge sys_clk) rd_q <= bus.rd;
    always @(negedge sys_clk) begin
        if (rd_q === 1'b1) begin
            if (expq.size() == 0)
                check("read queue", 16'h0001, 16'h0000);
            else
                check("rdata", rdata, expq.pop_front());
        end
    end

    initial begin
        bus = '0;
        rd_q = 1'b0;
        seed = 32'h51c0;
        port_four_in = 8'h00;
        fetch_pin_in = 1'b0;
        ext_irq_n = 1'b1;
        ext_irq_edge = 1'b0;
        power_down = 1'b0;
        update_done = 1'b0;
        flash_ready = 1'b0;
        mismatches = 0;
        cmp_count = 0;
        do_reset();
        rd(ADDR_AUX_CONFIG, AUX_RESET);
        rd(ADDR_WDT_CONTROL, WDT_RESET);
        rd(8'he5, 8'h00);
        // Timer1 undivided, generator on the divided clock, over 120 clocks
        wr(ADDR_AUX_CONFIG, 8'h50);
        idle(2);
        n = 0;
        m = 0;
        k = 0;
        repeat (120) begin
            @(negedge sys_clk);
            n += timer_tick0 + timer_tick1;
            m += port_strobe;
            k += baud_gen_tick;
        end
        check("timer ticks", 16'(n), 16'(120 / LEGACY_DIV + 120));
        check("baud gen ticks", 16'(k), 16'(120 / LEGACY_DIV));
        check("port strobes", 16'(m), 16'(120 / PORT_ACCESS_CLKS));
        check("baud source", baud_from_gen, 16'h0000);
        check("pins", {latch_pin_out, fetch_pin_out}, 16'h0001);
        // Random port latch, pin levels and aux values
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            wr(ADDR_PORT_FOUR, seed[7:0]);
            port_four_in <= seed[15:8];
            wr(ADDR_AUX_CONFIG, seed[23:16] | 8'h80);
            idle(3);
            @(negedge sys_clk);
            check("port out", port_four_out, seed[7:0]);
            rd(ADDR_PORT_FOUR, seed[15:8]);
            rd(ADDR_AUX_CONFIG, seed[23:16] | 8'h80);
        end
        // Good unlock launches the command at the register address
        wr(ADDR_IRQ_MASK, 8'h07);
        wr(ADDR_FP_ADDR_HIGH, 8'h12);
        wr(ADDR_FP_ADDR_LOW, 8'h34);
        wr(ADDR_FP_COMMAND, 8'h02);
        wr(ADDR_FP_TRIGGER, UNLOCK_FIRST);
        wr(ADDR_FP_TRIGGER, UNLOCK_SECOND);
        idle(1);
        wait_hi(flash_start, 3, n);
        check("flash addr", flash_addr, FLASH_BASE + 16'h1234);
        check("flash cmd", flash_cmd, 16'h0002);
        idle(1);
        flash_ready <= 1'b1;
        idle(1);
        flash_ready <= 1'b0;
        wait_hi(irq, 4, n);
        rd(ADDR_IRQ_STATUS, 8'h01);
        wr(ADDR_IRQ_STATUS, 8'h01);
        // Broken unlock is refused and flagged while masked
        wr(ADDR_IRQ_MASK, 8'h00);
        wr(ADDR_FP_TRIGGER, UNLOCK_FIRST);
        wr(ADDR_FP_TRIGGER, 8'h00);
        wr(ADDR_FP_TRIGGER, UNLOCK_SECOND);
        idle(3);
        @(negedge sys_clk);
        check("masked irq", irq, 16'h0000);
        rd(ADDR_IRQ_STATUS, 8'h04);
        wr(ADDR_IRQ_MASK, 8'h04);
        idle(1);
        wait_hi(irq, 4, n);
        wr(ADDR_IRQ_STATUS, 8'h04);
        idle(3);
        @(negedge sys_clk);
        check("cleared irq", irq, 16'h0000);
        // Wake delay: level mode on even selections, edge mode on odd
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_WAKE_CONTROL, 8'(i));
            ext_irq_edge <= i[0];
            power_down <= 1'b1;
            idle(3);
            ext_irq_n <= 1'b0;
            wait_hi(wake_resume, 33000, n);
            check("wake delay", 16'(n / 16), 16'((32768 >> i) / 16));
            idle(1);
            power_down <= 1'b0;
            ext_irq_n <= 1'b1;
            rd(ADDR_IRQ_STATUS, 8'h02);
            wr(ADDR_IRQ_STATUS, 8'h02);
        end
        // Watchdog fields, then enable after an update
        wr(ADDR_WDT_CONTROL, 8'h1f);
        idle(1);
        rd(ADDR_WDT_CONTROL, 8'h0f);
        update_done <= 1'b1;
        idle(1);
        update_done <= 1'b0;
        wait_hi(wdt_enabled, 4, n);
        wr(ADDR_WDT_CONTROL, 8'h00);
        idle(2);
        @(negedge sys_clk);
        check("watchdog on", wdt_enabled, 16'h0001);
        // Second reset restores the defaults
        do_reset();
        rd(ADDR_AUX_CONFIG, AUX_RESET);
        idle(2);
        @(negedge sys_clk);
        check("port reset", port_four_out, PORT_RESET);
        test_done();
    end
endmodule // esc_sfr_set_bench
`default_nettype wire
